// ---- rtl/ca_term_pkg.sv ----
// Package: constants and carrier types for the command bus termination block
package ca_term_pkg;

  // ****************************************************************
  // Field positions and widths
  // ****************************************************************
  localparam int STRENGTH_LSB       = 4;   // Strength field low bit
  localparam int STRENGTH_MSB       = 6;   // Strength field high bit
  localparam int CMD_DISABLE_BIT    = 3;   // Group register bit
  localparam int CLOCK_ENABLE_BIT   = 4;   // Group register bit
  localparam int SELECT_ENABLE_BIT  = 5;   // Group register bit
  localparam int CMD_LINE_COUNT     = 6;   // Terminated command lines

  // ****************************************************************
  // Codes and reset values
  // ****************************************************************
  localparam logic [2:0] STRENGTH_OFF   = 3'h0;  // Termination disabled
  localparam logic [2:0] STRENGTH_MAX   = 3'h6;  // Highest legal divider
  localparam logic [7:0] MODE_REG_RESET = 8'h00; // Both mode regs at reset
  localparam logic [7:0] OHMS_OFF       = 8'h00; // Shown when not applied

  // Pull-up calibration point
  typedef enum logic {
    PULLUP_VDDQ_DIV_2P5,
    PULLUP_VDDQ_DIV_3
  } pullup_level_t;

  // Termination enables for each group of the command bus
  typedef struct packed {
    logic                      clock_pair;  // Clock true/complement
    logic                      select_line; // Chip select
    logic [CMD_LINE_COUNT-1:0] cmd_lines;   // Command/address lines
  } term_groups_t;

  // Resolved strength: divider of the reference and nominal ohms
  typedef struct packed {
    logic [2:0] divider;
    logic [7:0] ohms;
  } strength_t;

endpackage : ca_term_pkg

// ---- rtl/strength_decode.sv ----
// Strength code to reference divider and nominal ohm decoder
`timescale 1ns/1ps
`default_nettype none

module strength_decode (
  input  wire logic                  [2:0] code,     // Three-bit code
  output var  ca_term_pkg::strength_t      strength  // Decoded value
);

  // Codes above the highest divider are reserved and read as off
  always_comb begin
    case (code)
      3'h1:    strength = {3'h1, 8'hF0};
      3'h2:    strength = {3'h2, 8'h78};
      3'h3:    strength = {3'h3, 8'h50};
      3'h4:    strength = {3'h4, 8'h3C};
      3'h5:    strength = {3'h5, 8'h30};
      3'h6:    strength = {3'h6, 8'h28};
      default: strength = {3'h0, ca_term_pkg::OHMS_OFF};
    endcase
  end

endmodule : strength_decode
`default_nettype wire

// ---- rtl/ca_termination_drive_config.sv ----
// Command/address termination and drive strength configuration
//
// Operation
// - Mode bits 6:4 pick termination as reference over one to six; zero off
// - After reset termination stays off until a non-zero code is written
// - Termination covers clock pair, select and six lines; no control pin
// - Termination stays applied during power-down and self-refresh
// - Strap low: command lines never terminated regardless of strength
// - Strap high with code one to six: terminate at the selected value
// - Power-down entry never changes the captured strap state
// - Group register bit 3 drops lines with strap high; bits 4, 5 add clock, select with strap low
// - Six pull-down drive strengths, reference over one to six
`timescale 1ns/1ps
`default_nettype none

module ca_termination_drive_config (
  input  wire logic                        clock,          // 25 MHz clock
  input  wire logic                        rst_n,          // Async reset
  input  wire logic                        rank_termination_strap, // Pad
  input  wire logic                        mode_write,     // Mode reg write
  input  wire logic                        mode_select,    // 0 str, 1 group
  input  wire logic                  [7:0] mode_data,      // Write operand
  input  wire logic                  [2:0] drive_code,     // Pull-down code
  input  wire logic                        pullup_sel,     // Cal point
  input  wire logic                        power_down,     // Power-down state
  output var  ca_term_pkg::term_groups_t   term_enable,    // Group enables
  output var  logic                  [7:0] term_ohms,      // Applied ohms
  output var  logic                  [2:0] term_divider,   // Applied divider
  output var  logic                  [7:0] pulldown_drive_resistance, // Ohms
  output var  logic                        strap_state,    // Captured strap
  output var  logic                        combo_invalid,  // Bad cal pairing
  output var  logic                        recal_needed    // Cal point moved
);

  // ****************************************************************
  // Strap synchroniser and capture
  // ****************************************************************
  logic strap_meta;
  logic strap_sync;
  logic strap_taken;

  // Two flops before any logic reads the pad
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      strap_meta <= 1'b0;
      strap_sync <= 1'b0;
    end else begin
      strap_meta <= rank_termination_strap;
      strap_sync <= strap_meta;
    end
  end

  // Strap held as a level; power-down has no say in it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      strap_taken <= 1'b0;
    end else begin
      strap_taken <= strap_sync;
    end
  end

  // ****************************************************************
  // Mode registers
  // ****************************************************************
  logic [7:0] termination_strength_mode_reg;
  logic [7:0] termination_group_mode_reg;
  wire        write_strength = mode_write & ~mode_select;
  wire        write_group    = mode_write & mode_select;

  // Reset clears both, so termination starts off
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      termination_strength_mode_reg <= ca_term_pkg::MODE_REG_RESET;
      termination_group_mode_reg    <= ca_term_pkg::MODE_REG_RESET;
    end else begin
      if (write_strength) begin
        termination_strength_mode_reg <= mode_data;
      end
      if (write_group) begin
        termination_group_mode_reg <= mode_data;
      end
    end
  end

  // ****************************************************************
  // Field decode
  // ****************************************************************
  wire [2:0] cmd_bus_term_strength = termination_strength_mode_reg[
    ca_term_pkg::STRENGTH_MSB:ca_term_pkg::STRENGTH_LSB];
  wire cmd_lines_term_disable  =
    termination_group_mode_reg[ca_term_pkg::CMD_DISABLE_BIT];
  wire clock_pair_term_enable  =
    termination_group_mode_reg[ca_term_pkg::CLOCK_ENABLE_BIT];
  wire select_line_term_enable =
    termination_group_mode_reg[ca_term_pkg::SELECT_ENABLE_BIT];

  ca_term_pkg::strength_t term_strength;
  ca_term_pkg::strength_t drive_strength;

  // Same decoder serves termination and pull-down drive
  strength_decode term_dec (
    .code     (cmd_bus_term_strength),
    .strength (term_strength)
  );
  strength_decode drive_dec (
    .code     (drive_code),
    .strength (drive_strength)
  );

  // ****************************************************************
  // Group decision
  // ****************************************************************
  // Reserved code 7 decodes to divider zero, so it also turns all off
  wire strength_on = term_strength.divider != ca_term_pkg::STRENGTH_OFF;
  wire lines_on    = strength_on & strap_taken &
                     ~cmd_lines_term_disable;
  wire clock_on    = strength_on &
                     (strap_taken | clock_pair_term_enable);
  wire select_on   = strength_on &
                     (strap_taken | select_line_term_enable);
  wire any_on      = lines_on | clock_on | select_on;

  ca_term_pkg::term_groups_t next_term_enable;
  assign next_term_enable.clock_pair  = clock_on;
  assign next_term_enable.select_line = select_on;
  assign next_term_enable.cmd_lines   =
    {ca_term_pkg::CMD_LINE_COUNT{lines_on}};

  // ****************************************************************
  // Calibration point check
  // ****************************************************************
  ca_term_pkg::pullup_level_t pullup_calibration_level;
  ca_term_pkg::pullup_level_t calibrated_level;
  assign pullup_calibration_level = pullup_sel ?
    ca_term_pkg::PULLUP_VDDQ_DIV_3 : ca_term_pkg::PULLUP_VDDQ_DIV_2P5;

  // The VDDQ/2.5 point cannot calibrate dividers four and up
  wire next_combo_invalid = strength_on &&
    pullup_calibration_level == ca_term_pkg::PULLUP_VDDQ_DIV_2P5 &&
    term_strength.divider > 3'h3;
  wire level_moved = pullup_calibration_level != calibrated_level;

  // Flags a moved point; strength changes alone never flag
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      calibrated_level <= ca_term_pkg::PULLUP_VDDQ_DIV_2P5;
      recal_needed     <= 1'b0;
    end else begin
      calibrated_level <= pullup_calibration_level;
      recal_needed     <= recal_needed | level_moved;
    end
  end

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  // power_down is deliberately unused: termination holds through it,
  // so one rank can keep terminating a command bus shared by sleepers
  wire unused_power_down = power_down;

  // Strength is only reported while some group actually terminates;
  // a programmed code with every group off shows as zero ohms
  wire [7:0] next_term_ohms    = any_on ? term_strength.ohms
                                        : ca_term_pkg::OHMS_OFF;
  wire [2:0] next_term_divider = any_on ? term_strength.divider
                                        : ca_term_pkg::STRENGTH_OFF;

  // Group enables; nothing here looks at the power state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      term_enable <= '0;
    end else begin
      term_enable <= next_term_enable;
    end
  end

  // Applied ohms, launched on the same edge as the enables
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      term_ohms <= ca_term_pkg::OHMS_OFF;
    end else begin
      term_ohms <= next_term_ohms;
    end
  end

  // Applied divider, kept in step with the ohms above
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      term_divider <= ca_term_pkg::STRENGTH_OFF;
    end else begin
      term_divider <= next_term_divider;
    end
  end

  // Pull-down drive follows its code one edge later
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pulldown_drive_resistance <= ca_term_pkg::OHMS_OFF;
    end else begin
      pulldown_drive_resistance <= drive_strength.ohms;
    end
  end

  // Strap copy leaves with the enables, so both always agree
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      strap_state <= 1'b0;
    end else begin
      strap_state <= strap_taken;
    end
  end

  // Pairing flag is a warning only; the strength is still applied
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      combo_invalid <= 1'b0;
    end else begin
      combo_invalid <= next_combo_invalid;
    end
  end

endmodule : ca_termination_drive_config
`default_nettype wire

// ---- bench/ca_term_asserts.sv ----
// Checker: timing and decode relations at the block ports
`timescale 1ns/1ps
`default_nettype none
module ca_term_asserts (
  input wire logic                 clock,         // Clock
  input wire logic                 rst_n,         // Reset
  input wire logic                 mode_write,    // Strobe
  input wire logic                 pullup_sel,    // Cal point
  input wire logic           [2:0] drive_code,    // Drive code
  input wire ca_term_pkg::term_groups_t term_enable, // Enables
  input wire logic           [7:0] term_ohms,     // Ohms
  input wire logic           [2:0] term_divider,  // Divider
  input wire logic           [7:0] pulldown_drive_resistance, // Drive
  input wire logic                 strap_state,   // Strap copy
  input wire logic                 combo_invalid, // Bad pair
  input wire logic                 recal_needed   // Recal flag
);
  // One domain; reset drops attempts in flight
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_ohm; term_ohms != 8'h00 |->
    16'(term_ohms) * 16'(term_divider) == 16'h00F0; endproperty
  a_ohm: assert property (p_ohm) else $error("ohms and divider");
  property p_low; !strap_state && !$past(strap_state) |->
    term_enable.cmd_lines == 6'h00; endproperty
  a_low: assert property (p_low) else $error("lines on");
  property p_high; strap_state && $past(strap_state) && term_ohms != 8'h00
    |-> term_enable.clock_pair && term_enable.select_line; endproperty
  a_high: assert property (p_high) else $error("clock off");
  // Power-down is no cause: only a write or the strap moves enables
  // Strap copy and enables leave the same register edge, so a strap
  // cause shows as a change of the copy in this very cycle
  property p_hold; $changed(term_enable) |-> $past(mode_write, 2) ||
    $changed(strap_state); endproperty
  a_hold: assert property (p_hold) else $error("moved");
  property p_drv; 1'b1 |=> 16'(pulldown_drive_resistance) *
    16'($past(drive_code)) == (($past(drive_code) inside {3'h0, 3'h7}) ?
    16'h0000 : 16'h00F0); endproperty
  a_drv: assert property (p_drv) else $error("drive ohms");
  property p_rcl; $changed(pullup_sel) |-> ##2 recal_needed; endproperty
  a_rcl: assert property (p_rcl) else $error("no recal");
  property p_stk; recal_needed |=> recal_needed; endproperty
  a_stk: assert property (p_stk) else $error("recal dropped");
  property p_cmb; combo_invalid |-> !$past(pullup_sel); endproperty
  a_cmb: assert property (p_cmb) else $error("bad pair flag");
endmodule : ca_term_asserts
bind ca_termination_drive_config ca_term_asserts u_ca_term_asserts (
  .clock, .rst_n, .mode_write, .pullup_sel, .drive_code, .term_enable,
  .term_ohms, .term_divider, .pulldown_drive_resistance, .strap_state,
  .combo_invalid, .recal_needed);
`default_nettype wire

// ---- bench/mode_ctrl_model.sv ----
// Controller model: mode register writes toward the die
`timescale 1ns/1ps
`default_nettype none
module mode_ctrl_model (
  input  wire logic       clock,       // Clock
  output var  logic       mode_write,  // Write strobe
  output var  logic       mode_select, // Register pick
  output var  logic [7:0] mode_data    // Operand
);
  // Idle at time zero
  initial begin
    mode_write  = 1'b0;
    mode_select = 1'b0;
    mode_data   = 8'h00;
  end
  // One-cycle pulse; released data is inverted so stale use shows
  task automatic write_reg(input logic sel, input logic [7:0] data);
    @(posedge clock);
    mode_write  <= 1'b1;
    mode_select <= sel;
    mode_data   <= data;
    @(posedge clock);
    mode_write  <= 1'b0;
    mode_data   <= ~data;
  endtask : write_reg
endmodule : mode_ctrl_model
`default_nettype wire

// ---- bench/tb_ca_termination_drive_config.sv ----
// Testbench: mode writes, strap and drive codes against expected decode
`timescale 1ns/1ps
`default_nettype none
module tb_ca_termination_drive_config;
  logic       clock;
  logic       rst_n = 1'b0;
  logic       rank_termination_strap = 1'b1;
  logic       pullup_sel = 1'b0;
  logic       power_down = 1'b0;
  logic [2:0] drive_code = 3'h0;
  logic       mode_write, mode_select, strap_state, combo_invalid;
  logic       recal_needed;
  logic [7:0] mode_data, term_ohms, pulldown_drive_resistance;
  logic [2:0] term_divider;
  int         error_cnt = 0, total_checks = 0;
  ca_term_pkg::term_groups_t term_enable;
  // Group writes and expected enables: strap high first, then low
  logic [7:0] gd [6] = '{8'h08, 8'h30, 8'h00, 8'h10, 8'h20, 8'h38};
  logic [7:0] ge [6] = '{8'hC0, 8'hFF, 8'h00, 8'h80, 8'h40, 8'hC0};
  ca_termination_drive_config u_ca_termination_drive_config (
    .clock, .rst_n, .rank_termination_strap, .mode_write, .mode_select,
    .mode_data, .drive_code, .pullup_sel, .power_down, .term_enable,
    .term_ohms, .term_divider, .pulldown_drive_resistance, .strap_state,
    .combo_invalid, .recal_needed);
  mode_ctrl_model u_mode_ctrl_model (.clock, .mode_write, .mode_select,
    .mode_data);
  // 25 MHz clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Whole run is about 130 cycles; this only catches a hang
  initial begin
    repeat (2000) @(posedge clock);
    error_cnt++;
    summarize();
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Let n edges land, then step past them
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : settle
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  // Main sequence
  initial begin
    int c;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    settle(5);
    chk(term_enable, 8'h00);
    chk(8'(strap_state), 8'h01);
    for (c = 1; c <= 7; c++) begin
      u_mode_ctrl_model.write_reg(1'b0, 8'(c << 4) | 8'h8F);
      settle(1);
      chk(term_enable, c < 7 ? 8'hFF : 8'h00);
      chk(term_ohms, c < 7 ? 8'(240 / c) : 8'h00);
      chk(8'(term_divider), c < 7 ? 8'(c) : 8'h00);
    end
    $display("test strength done");
    u_mode_ctrl_model.write_reg(1'b0, 8'h20);
    for (c = 0; c < 6; c++) begin
      if (c == 2) begin
        @(posedge clock) rank_termination_strap <= 1'b0;
        settle(5);
      end
      u_mode_ctrl_model.write_reg(1'b1, gd[c]);
      settle(1);
      chk(term_enable, ge[c]);
      chk(term_ohms, ge[c] != 8'h00 ? 8'h78 : 8'h00);
    end
    @(posedge clock) power_down <= 1'b1;
    settle(10);
    chk(term_enable, 8'hC0);
    chk(8'(strap_state), 8'h00);
    u_mode_ctrl_model.write_reg(1'b0, 8'h00);
    settle(1);
    chk(term_enable, 8'h00);
    @(posedge clock) power_down <= 1'b0;
    $display("test groups done");
    for (c = 0; c < 8; c++) begin
      @(posedge clock) drive_code <= 3'(c);
      settle(1);
      chk(pulldown_drive_resistance, (c > 0 && c < 7) ? 8'(240 / c) : 8'h00);
    end
    // Terminating rank is brought up before any calibration pairing
    @(posedge clock) rank_termination_strap <= 1'b1;
    settle(5);
    u_mode_ctrl_model.write_reg(1'b0, 8'h40);
    settle(1);
    chk(8'(combo_invalid), 8'h01);
    chk(8'(recal_needed), 8'h00);
    @(posedge clock) pullup_sel <= 1'b1;
    settle(3);
    chk(8'(combo_invalid), 8'h00);
    chk(8'(recal_needed), 8'h01);
    u_mode_ctrl_model.write_reg(1'b0, 8'h60);
    settle(1);
    chk(term_ohms, 8'h28);
    $display("test calibration done");
    // Mid-run reset drops termination until it is programmed again
    rst_n <= 1'b0;
    settle(2);
    chk(term_ohms, 8'h00);
    @(posedge clock) rst_n <= 1'b1;
    settle(5);
    chk(term_enable, 8'h00);
    chk(8'(term_divider), 8'h00);
    $display("test reset done");
    summarize();
  end
endmodule : tb_ca_termination_drive_config
`default_nettype wire
